// *** verilog/slsc_top.sv ***
// Contract
// - Audio infoframe checksum change clears audio FIFO
// - Video infoframe checksum change clears audio FIFO
// - Clock regeneration N/CTS change clears FIFO
// - Bit 7 shows downstream partner ready
// - Bit 6 shows transmitter active, remote locked
// - Transmit bit waits for input and mode
// - Port field valid only when transmitting
// - Bit 3 shows input decode good
// - Bit 2 shows receive PLL locked
// - Bit 0 shows input frequency stable
// - Status register read-only, resets to zero
// - Control bit 7 selects coax cabling
// - Cable bit loaded from strap pin
// - Bit 5 resets serial PLL on change
// - Bit 4 selects frequency detector clock
// - Capture only beyond hysteresis margin
// - Stable after selectable settle time
`timescale 1ns/100ps
`default_nettype none

module slsc_top #(
  parameter int SETTLE0 = slsc_pkg::SETTLE0_CYC,
  parameter int SETTLE1 = slsc_pkg::SETTLE1_CYC,
  parameter int SETTLE2 = slsc_pkg::SETTLE2_CYC,
  parameter int SETTLE3 = slsc_pkg::SETTLE3_CYC
) (
  input  wire logic                    clk,
  input  wire logic                    reset,
  input  wire logic                    hsel,
  input  wire logic [31:0]             haddr,
  input  wire logic [1:0]              htrans,
  input  wire logic                    hwrite,
  input  wire logic [2:0]              hsize,
  input  wire logic [31:0]             hwdata,
  input  wire logic                    hready,
  output logic                         hreadyout,
  output logic                         hresp,
  output logic [31:0]                  hrdata,
  input  wire slsc_pkg::slsc_link_in_t link_in,
  input  wire logic                    cable_strap_pin,
  input  wire logic                    aif_valid,
  input  wire logic [7:0]              aif_checksum,
  input  wire logic                    avi_valid,
  input  wire logic [7:0]              avi_checksum,
  input  wire logic                    acr_valid,
  input  wire slsc_pkg::slsc_acr_t     acr,
  input  wire logic                    freq_sample_valid,
  input  wire logic [7:0]              freq_raw_mhz,
  input  wire logic [7:0]              freq_pll_mhz,
  output logic                         audio_fifo_clear,
  output logic                         serial_pll_reset,
  output logic                         freq_detect_source_select,
  output logic                         cable_type_coax_select,
  output logic                         irq
);

  // =====================================================================
  // Register state
  logic [7:0]                clear_ctl_q;
  logic [7:0]                status_q;
  logic [7:0]                control_q;
  logic [7:0]                freq_cfg_q;
  logic [slsc_pkg::IRQ_W-1:0] irq_sts_q;
  logic [slsc_pkg::IRQ_W-1:0] irq_mask_q;
  logic                      strap_done_q;

  // Bus phase state
  logic                      wr_pend_q;
  logic                      rd_pend_q;
  logic [7:0]                idx_q;
  logic [31:0]               hrdata_q;

  // Event state
  logic [7:0]                aif_prev_q;
  logic [7:0]                avi_prev_q;
  slsc_pkg::slsc_acr_t       acr_prev_q;
  logic                      aif_seen_q;
  logic                      avi_seen_q;
  logic                      acr_seen_q;
  logic                      fifo_clear_q;
  logic                      pll_reset_q;
  logic [7:0]                freq_cur_q;
  logic [15:0]               settle_cnt_q;
  logic                      steady_q;

  logic                      addr_ok;
  logic                      aif_chg;
  logic                      avi_chg;
  logic                      acr_chg;
  logic                      freq_chg;
  logic                      steady_rise;
  logic                      link_rise;
  logic                      irq_rd;
  logic [7:0]                meas;
  logic [7:0]                diff;
  logic [15:0]               settle_lim;
  logic [7:0]                status_d;
  logic [slsc_pkg::IRQ_W-1:0] irq_evt;

  // Word index from a byte address; upper bits must be zero
  function automatic logic hit(input logic [31:0] a, input logic [7:0] idx);
    hit = (a[31:10] == 22'h000000) && (a[9:2] == idx);
  endfunction : hit

  // =====================================================================
  // AHB-Lite slave: writes take zero waits, reads insert one wait
  assign addr_ok   = hsel && htrans[1] && hready;
  assign hreadyout = !rd_pend_q;
  assign hresp     = 1'b0;
  assign hrdata    = hrdata_q;
  assign irq_rd    = rd_pend_q && (idx_q == slsc_pkg::IDX_IRQ_STATUS);

  // Address phase capture
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      wr_pend_q <= 1'b0;
      rd_pend_q <= 1'b0;
      idx_q     <= 8'h00;
    end else begin
      wr_pend_q <= addr_ok && hwrite && (haddr[31:10] == 22'h000000);
      rd_pend_q <= addr_ok && !hwrite;
      if (addr_ok) begin
        idx_q <= (haddr[31:10] == 22'h000000) ? haddr[9:2] : 8'hFF;
      end
    end
  end

  // Read data is sampled in the wait cycle so a preceding write is seen
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      hrdata_q <= 32'h00000000;
    end else if (rd_pend_q) begin
      case (idx_q)
        slsc_pkg::IDX_AUDIO_CLEAR: hrdata_q <= {24'h000000, clear_ctl_q};
        slsc_pkg::IDX_STATUS:      hrdata_q <= {24'h000000, status_q};
        slsc_pkg::IDX_CONTROL:     hrdata_q <= {24'h000000, control_q};
        slsc_pkg::IDX_FREQ_CFG:    hrdata_q <= {24'h000000, freq_cfg_q};
        slsc_pkg::IDX_IRQ_STATUS:  hrdata_q <= {28'h0000000, irq_sts_q};
        slsc_pkg::IDX_IRQ_MASK:    hrdata_q <= {28'h0000000, irq_mask_q};
        default:                   hrdata_q <= 32'h00000000;
      endcase
    end
  end

  // =====================================================================
  // Software control registers
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      clear_ctl_q <= slsc_pkg::RST_AUDIO_CLEAR;
      freq_cfg_q  <= slsc_pkg::RST_FREQ_CFG;
      irq_mask_q  <= '0;
    end else if (wr_pend_q) begin
      case (idx_q)
        slsc_pkg::IDX_AUDIO_CLEAR:
          clear_ctl_q <= hwdata[7:0] & slsc_pkg::AUDIO_CLEAR_MASK;
        slsc_pkg::IDX_FREQ_CFG:  freq_cfg_q <= {3'h0, hwdata[4:0]};
        slsc_pkg::IDX_IRQ_MASK:  irq_mask_q <= hwdata[slsc_pkg::IRQ_W-1:0];
        default: ;
      endcase
    end
  end

  // Control register; the cable bit comes from the strap after reset
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      control_q    <= slsc_pkg::RST_CONTROL;
      strap_done_q <= 1'b0;
    end else begin
      strap_done_q <= 1'b1;
      if (!strap_done_q) begin
        control_q[slsc_pkg::B_COAX] <= cable_strap_pin;
      end else if (wr_pend_q && idx_q == slsc_pkg::IDX_CONTROL) begin
        control_q <= hwdata[7:0] & slsc_pkg::CONTROL_WR_MASK;
      end
    end
  end

  assign cable_type_coax_select    = control_q[slsc_pkg::B_COAX];
  assign freq_detect_source_select = control_q[slsc_pkg::B_FDET_SRC];

  // =====================================================================
  // Status register: hardware driven only, bus writes never reach it
  always_comb begin
    status_d = 8'h00;
    status_d[slsc_pkg::B_LINK_READY]  = link_in.downstream_link_ready;
    status_d[slsc_pkg::B_TX_ACTIVE]   = link_in.transmitter_on &&
                                        link_in.remote_locked &&
                                        link_in.input_detected &&
                                        link_in.mode_entered;
    if (status_d[slsc_pkg::B_TX_ACTIVE]) begin
      status_d[5:4] = link_in.serial_port_mode;
    end
    status_d[slsc_pkg::B_DECODE_GOOD] = link_in.input_decode_good;
    status_d[slsc_pkg::B_PLL_LOCK]    = link_in.rx_pll_locked;
    status_d[slsc_pkg::B_NO_CLOCK]    = link_in.no_input_clock;
    status_d[slsc_pkg::B_FREQ_STEADY] = steady_q;
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      status_q <= slsc_pkg::RST_STATUS;
    end else begin
      status_q <= status_d;
    end
  end

  // =====================================================================
  // Infoframe and clock regeneration change detection
  // First frame after reset only primes the history, nothing to compare
  assign aif_chg = aif_valid && aif_seen_q && (aif_checksum != aif_prev_q);
  assign avi_chg = avi_valid && avi_seen_q && (avi_checksum != avi_prev_q);
  assign acr_chg = acr_valid && acr_seen_q && (acr != acr_prev_q);

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      aif_prev_q <= 8'h00;
      avi_prev_q <= 8'h00;
      acr_prev_q <= '0;
      aif_seen_q <= 1'b0;
      avi_seen_q <= 1'b0;
      acr_seen_q <= 1'b0;
    end else begin
      if (aif_valid) begin
        aif_prev_q <= aif_checksum;
        aif_seen_q <= 1'b1;
      end
      if (avi_valid) begin
        avi_prev_q <= avi_checksum;
        avi_seen_q <= 1'b1;
      end
      if (acr_valid) begin
        acr_prev_q <= acr;
        acr_seen_q <= 1'b1;
      end
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      fifo_clear_q <= 1'b0;
    end else begin
      fifo_clear_q <= (aif_chg && clear_ctl_q[slsc_pkg::B_CLR_AIF]) ||
                      (avi_chg && clear_ctl_q[slsc_pkg::B_CLR_AVI]) ||
                      (acr_chg && clear_ctl_q[slsc_pkg::B_CLR_ACR]);
    end
  end
  assign audio_fifo_clear = fifo_clear_q;

  // =====================================================================
  // Frequency detector
  // measurement source
  assign meas = control_q[slsc_pkg::B_FDET_SRC] ? freq_pll_mhz : freq_raw_mhz;
  assign diff = (meas > freq_cur_q) ? meas - freq_cur_q : freq_cur_q - meas;
  assign freq_chg = freq_sample_valid && (diff > {5'h00, freq_cfg_q[2:0]});

  always_comb begin
    case (freq_cfg_q[4:3])
      2'h0:    settle_lim = 16'(SETTLE0);
      2'h1:    settle_lim = 16'(SETTLE1);
      2'h2:    settle_lim = 16'(SETTLE2);
      default: settle_lim = 16'(SETTLE3);
    endcase
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      freq_cur_q   <= 8'h00;
      settle_cnt_q <= 16'h0000;
      steady_q     <= 1'b0;
    end else if (freq_chg) begin
      freq_cur_q   <= meas;
      settle_cnt_q <= 16'h0000;
      steady_q     <= 1'b0;
    end else begin
      if (settle_cnt_q != 16'hFFFF) begin
        settle_cnt_q <= settle_cnt_q + 16'h0001;
      end
      steady_q <= (settle_cnt_q >= settle_lim);
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      pll_reset_q <= 1'b0;
    end else begin
      pll_reset_q <= freq_chg && control_q[slsc_pkg::B_PLL_RST_EN];
    end
  end
  assign serial_pll_reset = pll_reset_q;

  // =====================================================================
  // Interrupts: set wins over the read clear so no event is lost
  assign steady_rise = freq_chg ? 1'b0 :
                       (!steady_q && settle_cnt_q >= settle_lim);
  assign link_rise   = link_in.downstream_link_ready &&
                       !status_q[slsc_pkg::B_LINK_READY];
  assign irq_evt     = {link_rise, steady_rise, freq_chg, fifo_clear_q};

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      irq_sts_q <= '0;
    end else begin
      irq_sts_q <= (irq_rd ? '0 : irq_sts_q) | irq_evt;
    end
  end
  assign irq = |(irq_sts_q & irq_mask_q);

  // =====================================================================
  // Checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  sequence s_aif_change;
    aif_valid && aif_seen_q && aif_checksum != aif_prev_q;
  endsequence
  sequence s_avi_change;
    avi_valid && avi_seen_q && avi_checksum != avi_prev_q;
  endsequence

  a_aif_fifo_clear: assert property (
    s_aif_change and clear_ctl_q[slsc_pkg::B_CLR_AIF] |=> audio_fifo_clear)
    else $error("audio infoframe change did not clear fifo");
  a_avi_fifo_clear: assert property (
    s_avi_change and clear_ctl_q[slsc_pkg::B_CLR_AVI] |=> audio_fifo_clear)
    else $error("video infoframe change did not clear fifo");
  a_acr_fifo_clear: assert property (
    (acr_valid && acr_seen_q && acr != acr_prev_q &&
     clear_ctl_q[slsc_pkg::B_CLR_ACR])
    |=> audio_fifo_clear)
    else $error("clock regeneration change did not clear fifo");
  a_link_ready_bit: assert property (
    ##1 status_q[7] == $past(link_in.downstream_link_ready))
    else $error("link ready bit does not follow partner");
  a_tx_gate_mode: assert property (
    status_q[6] |-> $past(link_in.input_detected && link_in.mode_entered
                          && link_in.transmitter_on))
    else $error("transmit bit set before input and mode");
  a_port_idle_zero: assert property (
    !status_q[6] |-> status_q[5:4] == 2'h0)
    else $error("port field nonzero while not transmitting");
  a_pll_lock_bit: assert property (
    ##1 status_q[2] == $past(link_in.rx_pll_locked))
    else $error("pll lock bit does not follow receiver");
  a_pll_reset_gate: assert property (
    freq_chg |=>
      serial_pll_reset == $past(control_q[slsc_pkg::B_PLL_RST_EN]))
    else $error("serial pll reset not per control bit");
  a_steady_settle: assert property (
    freq_chg ##1 !freq_chg [*3] |-> !status_q[0] ##1 !status_q[0])
    else $error("frequency stable too soon after change");
  a_status_ro: assert property (
    wr_pend_q && idx_q == slsc_pkg::IDX_STATUS |=>
      status_q == $past(status_d))
    else $error("status register changed by a write");

endmodule : slsc_top

`default_nettype wire

// *** verilog/slsc_pkg.sv ***
// =====================================================================
// Shared constants and carriers for the link status and control bank
package slsc_pkg;

  // =====================================================================
  // Register indices; byte address is four times the index
  localparam logic [7:0]  IDX_AUDIO_CLEAR   = 8'h55;
  localparam logic [7:0]  IDX_STATUS        = 8'h5A;
  localparam logic [7:0]  IDX_CONTROL       = 8'h5B;
  localparam logic [7:0]  IDX_FREQ_CFG      = 8'h5C;
  localparam logic [7:0]  IDX_IRQ_STATUS    = 8'h60;
  localparam logic [7:0]  IDX_IRQ_MASK      = 8'h61;

  // =====================================================================
  // Field positions
  localparam int          B_CLR_AIF         = 2;
  localparam int          B_CLR_AVI         = 1;
  localparam int          B_CLR_ACR         = 0;
  localparam int          B_LINK_READY      = 7;
  localparam int          B_TX_ACTIVE       = 6;
  localparam int          B_PORT_LO         = 4;
  localparam int          B_DECODE_GOOD     = 3;
  localparam int          B_PLL_LOCK        = 2;
  localparam int          B_NO_CLOCK        = 1;
  localparam int          B_FREQ_STEADY     = 0;
  localparam int          B_COAX            = 7;
  localparam int          B_PLL_RST_EN      = 5;
  localparam int          B_FDET_SRC        = 4;
  localparam int          B_SETTLE_LO       = 3;

  // =====================================================================
  // Reset values and masks
  localparam logic [7:0]  RST_AUDIO_CLEAR   = 8'h00;
  localparam logic [7:0]  RST_STATUS        = 8'h00;
  localparam logic [7:0]  RST_CONTROL       = 8'h20;
  localparam logic [7:0]  RST_FREQ_CFG      = 8'h02;
  localparam logic [7:0]  CONTROL_WR_MASK   = 8'hB0;
  localparam logic [7:0]  AUDIO_CLEAR_MASK  = 8'h07;
  localparam logic [1:0]  PORT_SINGLE_P0    = 2'h1;
  localparam int          IRQ_W             = 4;

  // =====================================================================
  // Settle times in microseconds and clock rate
  localparam int          CLK_MHZ           = 40;
  localparam int          SETTLE0_US        = 40;
  localparam int          SETTLE1_US        = 80;
  localparam int          SETTLE2_US        = 320;
  localparam int          SETTLE3_US        = 1280;
  localparam int          SETTLE0_CYC       = SETTLE0_US * CLK_MHZ;
  localparam int          SETTLE1_CYC       = SETTLE1_US * CLK_MHZ;
  localparam int          SETTLE2_CYC       = SETTLE2_US * CLK_MHZ;
  localparam int          SETTLE3_CYC       = SETTLE3_US * CLK_MHZ;

  // =====================================================================
  // Carriers
  typedef struct packed {
    logic       downstream_link_ready;
    logic       transmitter_on;
    logic       remote_locked;
    logic       input_detected;
    logic       mode_entered;
    logic [1:0] serial_port_mode;
    logic       input_decode_good;
    logic       rx_pll_locked;
    logic       no_input_clock;
  } slsc_link_in_t;

  typedef struct packed {
    logic [19:0] n_value;
    logic [19:0] cts_value;
  } slsc_acr_t;

endpackage : slsc_pkg

// *** verification/slsc_remote_rx.sv ***
`timescale 1ns/100ps
`default_nettype none

// =====================================================================
// Far-end receiver: locks after a delay, loses lock on every PLL restart
module slsc_remote_rx (
  input  wire logic clk,
  input  wire logic reset,
  input  wire logic pll_reset,
  input  wire logic slow,
  output logic      locked
);
  logic [5:0] wait_q;

  // Relock count; slow mode keeps lock lost long enough to be read back
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      wait_q <= 6'h28;
    end else if (pll_reset) begin
      wait_q <= slow ? 6'h28 : 6'h02;
    end else if (wait_q != 6'h00) begin
      wait_q <= wait_q - 6'h01;
    end
  end

  assign locked = (wait_q == 6'h00);
endmodule : slsc_remote_rx

`default_nettype wire

// *** verification/serial_link_status_control_tb.sv ***
`timescale 1ns/100ps
`default_nettype none

module serial_link_status_control_tb;
  logic                   clk;
  logic                   reset, hsel, hwrite, strap, slow;
  logic                   aif_v, avi_v, acr_v, fs_v, rdy_n, irq_n;
  logic [31:0]            haddr, hwdata, rd_n, q;
  logic [1:0]             htrans;
  logic [7:0]             aif_c, avi_c, f_raw, f_pll, lk;
  slsc_pkg::slsc_acr_t    acr;
  slsc_pkg::slsc_link_in_t link_in;
  wire                    hreadyout, hresp, fifo_clr, pll_rst;
  wire                    fdet, coax, irq, locked;
  wire [31:0]             hrdata;
  int                     fails, samples_checked, n_clr, n_prst, n0;
  // Rows: tb link bits (on,det,mode,port,dec,pll,noclk), status expected
  logic [15:0]            rows [6] = '{16'h0080, 16'hEEDC, 16'hC880,
                                       16'h6982, 16'hB284, 16'hF0E0};

  // =====================================================================
  // Clock, partner and design
  always #12.5 clk = ~clk;
  assign link_in = slsc_pkg::slsc_link_in_t'({locked, lk[7], locked, lk[6:0]});

  slsc_remote_rx far_end (.clk(clk), .reset(reset), .pll_reset(pll_rst),
                          .slow(slow), .locked(locked));

  // Short settle counts keep the run brief
  slsc_top #(.SETTLE0(8), .SETTLE1(16), .SETTLE2(32), .SETTLE3(64)) dut (
    .clk(clk), .reset(reset), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
    .link_in(link_in), .cable_strap_pin(strap), .aif_valid(aif_v),
    .aif_checksum(aif_c), .avi_valid(avi_v), .avi_checksum(avi_c),
    .acr_valid(acr_v), .acr(acr), .freq_sample_valid(fs_v),
    .freq_raw_mhz(f_raw), .freq_pll_mhz(f_pll), .audio_fifo_clear(fifo_clr),
    .serial_pll_reset(pll_rst), .freq_detect_source_select(fdet),
    .cable_type_coax_select(coax), .irq(irq));

  // Sample combinational outputs mid-cycle, clear of edge races
  always @(negedge clk) begin
    rdy_n = hreadyout;
    rd_n  = hrdata;
    irq_n = irq;
  end

  // Pulse counters sampled mid-cycle: a check made at the next rising
  // edge would otherwise race the count of a pulse ending there
  always @(negedge clk) begin
    if (fifo_clr === 1'b1) n_clr++;
    if (pll_rst === 1'b1) n_prst++;
  end

  // =====================================================================
  // Tasks
  task automatic close_out;
    $display("checks=%0d mismatches=%0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : close_out

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      fails++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic wait_rdy;
    int n;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (rdy_n !== 1'b1 && n < 20);
    if (rdy_n !== 1'b1) begin
      fails++;
      close_out();
    end
  endtask : wait_rdy

  // One single-word transfer; address held until ready, then data phase
  task automatic bus(input logic wr, input logic [7:0] idx,
                     input logic [7:0] d);
    hsel   <= 1'b1;
    haddr  <= {22'h0, idx, 2'h0};
    htrans <= 2'h2;
    hwrite <= wr;
    wait_rdy();
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= {24'h0, d};
    wait_rdy();
    q = rd_n;
  endtask : bus

  task automatic strobe(input int s, input logic [7:0] v);
    aif_v <= (s == 0);
    avi_v <= (s == 1);
    acr_v <= (s == 2);
    aif_c <= v;
    avi_c <= v;
    acr   <= {12'h0, v, 12'h0, v};
    @(posedge clk);
    {aif_v, avi_v, acr_v} <= 3'h0;
    @(posedge clk);
  endtask : strobe

  task automatic fsamp(input logic [7:0] raw, input logic [7:0] pll);
    f_raw <= raw;
    f_pll <= pll;
    fs_v  <= 1'b1;
    @(posedge clk);
    fs_v  <= 1'b0;
    @(posedge clk);
  endtask : fsamp

  task automatic do_reset(input logic s);
    reset <= 1'b1;
    strap <= s;
    repeat (8) @(posedge clk);
    reset <= 1'b0;
    @(posedge clk);
  endtask : do_reset

  // =====================================================================
  // Watchdog against a hung run
  initial begin
    repeat (20000) @(posedge clk);
    fails++;
    close_out();
  end

  // =====================================================================
  // Main sequence
  initial begin
    clk = 1'b0; reset = 1'b1; hsel = 1'b0; haddr = '0; htrans = 2'h0;
    hwrite = 1'b0; hwdata = '0; strap = 1'b1; slow = 1'b1; lk = 8'h00;
    {aif_v, avi_v, acr_v, fs_v} = 4'h0; aif_c = 8'h00; avi_c = 8'h00;
    acr = '0; f_raw = 8'h00; f_pll = 8'h00;
    fails = 0; samples_checked = 0; n_clr = 0; n_prst = 0;
    do_reset(1'b1);
    bus(1'b0, slsc_pkg::IDX_STATUS, 8'h00); chk(q, 32'h0);
    bus(1'b1, slsc_pkg::IDX_STATUS, 8'hFF);
    bus(1'b0, slsc_pkg::IDX_STATUS, 8'h00); chk(q & 32'hFE, 32'h0);
    bus(1'b0, slsc_pkg::IDX_CONTROL, 8'h00); chk(q, 32'hA0);
    chk({hresp, coax}, 32'h1);
    repeat (50) @(posedge clk);
    // Status rows; frequency bit masked here, tested below
    foreach (rows[i]) begin
      lk <= rows[i][15:8];
      repeat (2) @(posedge clk);
      bus(1'b0, slsc_pkg::IDX_STATUS, 8'h00);
      chk(q & 32'hFE, {24'h0, rows[i][7:0]});
      chk(q & 32'h0E, {24'h0, rows[i][7:0] & 8'h0E});
    end
    bus(1'b1, slsc_pkg::IDX_CONTROL, 8'hFF);
    bus(1'b0, slsc_pkg::IDX_CONTROL, 8'h00); chk(q, 32'hB0);
    chk({coax, fdet}, 32'h3);
    bus(1'b1, slsc_pkg::IDX_CONTROL, 8'h00);
    bus(1'b0, slsc_pkg::IDX_CONTROL, 8'h00); chk(q, 32'h0);
    chk({coax, fdet}, 32'h0);
    bus(1'b0, 8'h70, 8'h00); chk(q, 32'h0);
    for (int s = 0; s < 3; s++) strobe(s, 8'h00);
    for (int s = 0; s < 3; s++) begin
      bus(1'b1, slsc_pkg::IDX_AUDIO_CLEAR, 8'h04 >> s);
      n0 = n_clr;
      for (int k = 0; k < 3; k++) strobe(k, 8'(s + 1));
      strobe(s, 8'(s + 1));
      chk(n_clr - n0, 32'h1);
    end
    // Sticky events so far: fifo clear, settle, link rise; read clears all
    chk(irq_n, 32'h0);
    bus(1'b1, slsc_pkg::IDX_IRQ_MASK, 8'h01);
    @(posedge clk); chk(irq_n, 32'h1);
    bus(1'b0, slsc_pkg::IDX_IRQ_STATUS, 8'h00); chk(q, 32'hD);
    @(posedge clk); chk(irq_n, 32'h0);
    bus(1'b0, slsc_pkg::IDX_IRQ_STATUS, 8'h00); chk(q, 32'h0);
    bus(1'b1, slsc_pkg::IDX_FREQ_CFG, 8'h02);
    bus(1'b1, slsc_pkg::IDX_CONTROL, 8'hA0);
    n0 = n_prst;
    fsamp(8'd50, 8'd0); fsamp(8'd52, 8'd0); fsamp(8'd53, 8'd0);
    repeat (3) @(posedge clk);
    bus(1'b0, slsc_pkg::IDX_STATUS, 8'h00); chk(q & 32'hC1, 32'h0);
    chk(n_prst - n0, 32'h2);
    repeat (60) @(posedge clk);
    bus(1'b0, slsc_pkg::IDX_STATUS, 8'h00); chk(q & 32'hC1, 32'hC1);
    bus(1'b1, slsc_pkg::IDX_CONTROL, 8'hB0);
    n0 = n_prst;
    fsamp(8'd90, 8'd54); chk(n_prst - n0, 32'h0);
    bus(1'b1, slsc_pkg::IDX_CONTROL, 8'h80);
    fsamp(8'd20, 8'd20); chk(n_prst - n0, 32'h0);
    // Longest settle select: not stable at 50 cycles, stable by 75
    bus(1'b1, slsc_pkg::IDX_FREQ_CFG, 8'h1A);
    fsamp(8'd40, 8'd0);
    repeat (50) @(posedge clk);
    bus(1'b0, slsc_pkg::IDX_STATUS, 8'h00); chk(q & 32'h1, 32'h0);
    repeat (20) @(posedge clk);
    bus(1'b0, slsc_pkg::IDX_STATUS, 8'h00); chk(q & 32'h1, 32'h1);
    // strap low on a second reset
    do_reset(1'b0);
    bus(1'b0, slsc_pkg::IDX_CONTROL, 8'h00); chk(q, 32'h20);
    chk(coax, 32'h0);
    close_out();
  end
endmodule : serial_link_status_control_tb

`default_nettype wire
